// ### rtl/pixel_serial_link_codec.sv
// serializer framing and coding, with the matching receive decoder
//
// Overview of operation
// - carry 24 colour plus 3 control bits
// - clock bits: first high, second low
// - payload is scrambled colour data
// - balance flag inverts payload to limit bias
// - integrity bit validates and carries control
// - coding generated and decoded automatically
// - 24-bit mode: control only in integrity bit
// - 18-bit mode: control in payload optional
// - filter suppresses control-line glitches
// - receiver locks on any data pattern
// - tolerate spread-spectrum pixel clock
// - output level select low standard, high raised
// - configuration by external pins
`include "pixel_link_params.svh"
module pixel_serial_link_codec
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pclk_i,
    input wire logic [23:0] colour_bits_i,
    input wire logic frame_sync_i,
    input wire logic line_sync_i,
    input wire logic pixel_valid_i,
    input wire logic [2:0] gp_bits_i,
    input wire logic mode_18_i,
    input wire logic ctrl_in_payload_i,
    input wire logic filter_en_i,
    input wire logic output_level_select_i,
    input wire logic [27:0] rx_frame_i,
    input wire logic rx_frame_valid_i,
    output logic [27:0] tx_frame_o,
    output logic tx_frame_valid_o,
    output logic [11:0] vod_mv_o,
    output logic [23:0] rx_colour_bits_o,
    output logic rx_frame_sync_o,
    output logic rx_line_sync_o,
    output logic rx_pixel_valid_o,
    output logic [2:0] rx_gp_bits_o,
    output logic rx_pixel_strobe_o,
    output logic rx_lock_o,
    output logic rx_integrity_err_o
);
    // two-flop synchronisers for every pin-side input
    logic [1:0] pclk_sync_r;
    logic pclk_prev_r;
    pixel_link_pkg::pixel_word_t pix_s1_r;
    pixel_link_pkg::pixel_word_t pix_s2_r;
    logic [2:0] gp_s1_r;
    logic [2:0] gp_s2_r;
    logic [3:0] cfg_s1_r;
    logic [3:0] cfg_s2_r;
    logic [28:0] rx_s1_r;
    logic [28:0] rx_s2_r;
    logic rx_prev_valid_r;

    // scrambler state and running disparity
    logic [15:0] tx_lfsr_r;
    logic [15:0] rx_lfsr_r;
    logic signed [7:0] disparity_r;
    logic [1:0] ctrl_phase_r;
    logic [1:0] rx_phase_r;
    logic [15:0] idle_cnt_r;

    // filtered control levels
    logic fs_filt;
    logic ls_filt;
    logic pv_filt;
    logic pclk_rise;

    // rising edge found on the synchronised pixel clock only
    assign pclk_rise = pclk_sync_r[1] & ~pclk_prev_r;

    // advance a 16-bit lfsr by 24 steps, returning the keystream
    function automatic logic [39:0] lfsr_step(input logic [15:0] s);
        logic [15:0] st;
        logic [23:0] ks;
        st = s;
        ks = 24'h0;
        for (int i = 0; i < 24; i++)
        begin
            ks[i] = st[0];
            st = {st[0] ^ st[2] ^ st[3] ^ st[5], st[15:1]};
        end
        return {st, ks};
    endfunction

    // count ones in a payload word
    function automatic logic [4:0] ones(input logic [23:0] w);
        logic [4:0] n;
        n = 5'h0;
        for (int i = 0; i < 24; i++)
            n = n + {4'h0, w[i]};
        return n;
    endfunction

    // parity over payload and flag, used as the integrity check
    function automatic logic parity(input logic [23:0] w, input logic f);
        return ^{w, f};
    endfunction

    // synchronise pins; the link clock is sampled like any pin
    // pixel word, pin config
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pclk_sync_r <= 2'h0;
            // high, but the synchroniser clears low, so a pin held high across reset still gives one edge after release
            pclk_prev_r <= 1'b1;
            pix_s1_r <= '0;
            pix_s2_r <= '0;
            gp_s1_r <= 3'h0;
            gp_s2_r <= 3'h0;
            cfg_s1_r <= 4'h0;
            cfg_s2_r <= 4'h0;
            rx_s1_r <= '0;
            rx_s2_r <= '0;
            rx_prev_valid_r <= 1'b0;
        end
        else
        begin
            pclk_sync_r <= {pclk_sync_r[0], pclk_i};
            pclk_prev_r <= pclk_sync_r[1];
            pix_s1_r <= {colour_bits_i, frame_sync_i, line_sync_i, pixel_valid_i};
            pix_s2_r <= pix_s1_r;
            gp_s1_r <= gp_bits_i;
            gp_s2_r <= gp_s1_r;
            cfg_s1_r <= {mode_18_i, ctrl_in_payload_i, filter_en_i, output_level_select_i};
            cfg_s2_r <= cfg_s1_r;
            rx_s1_r <= {rx_frame_valid_i, rx_frame_i};
            rx_s2_r <= rx_s1_r;
            rx_prev_valid_r <= rx_s2_r[28];
        end
    end

    ctrl_glitch_filter u_fs
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .step_i(pclk_rise),
        .enable_i(cfg_s2_r[1]),
        .raw_i(pix_s2_r.frame_sync),
        .filt_o(fs_filt)
    );
    ctrl_glitch_filter u_ls
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .step_i(pclk_rise),
        .enable_i(cfg_s2_r[1]),
        .raw_i(pix_s2_r.line_sync),
        .filt_o(ls_filt)
    );
    ctrl_glitch_filter u_pv
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .step_i(pclk_rise),
        .enable_i(cfg_s2_r[1]),
        .raw_i(pix_s2_r.pixel_valid),
        .filt_o(pv_filt)
    );

    // tracks modulated clock
    // build one frame per rising pixel clock edge; frames follow the sampled clock
    // so spread-spectrum drift is tracked with no local rate assumption
    always_ff @(posedge clk_i)
    begin
        logic [39:0] step;
        logic [23:0] data;
        logic [23:0] scr;
        logic inv;
        logic ictl;
        logic signed [7:0] delta;
        step = lfsr_step(tx_lfsr_r);
        data = pix_s2_r.colour_bits;
        inv = 1'b0;
        ictl = 1'b0;
        delta = 8'sh0;
        if (rst_i)
        begin
            tx_frame_o <= '0;
            tx_frame_valid_o <= 1'b0;
            tx_lfsr_r <= `SCRAMBLE_SEED;
            disparity_r <= 8'sh0;
            ctrl_phase_r <= 2'h0;
        end
        else if (pclk_rise)
        begin
            if (cfg_s2_r[3] && cfg_s2_r[2])
                data = {pix_s2_r.colour_bits[23:6], gp_s2_r, fs_filt, ls_filt, pv_filt};
            scr = data ^ step[23:0];
            // disparity in line bits: ones minus zeros of the payload
            delta = $signed({2'h0, ones(scr), 1'b0}) - 8'sh18;
            // invert when it worsens running disparity
            // a balanced word is inverted below zero so the flag bit pulls up
            inv = (disparity_r > 0 && delta > 0) || (disparity_r < 0 && delta <= 0);
            if (inv)
            begin
                scr = ~scr;
                delta = -delta;
            end
            // parity, with one control bit rotated into three frames of each four, none when controls ride in the payload
            ictl = parity(scr, inv);
            if (!(cfg_s2_r[3] && cfg_s2_r[2]))
            begin
                case (ctrl_phase_r)
                    2'h0: ictl = ictl ^ fs_filt;
                    2'h1: ictl = ictl ^ ls_filt;
                    2'h2: ictl = ictl ^ pv_filt;
                    default: ictl = ictl;
                endcase
            end
            // flag and integrity bits are on the line as well, so count them
            delta = delta + (inv ? 8'sh01 : -8'sh01) + (ictl ? 8'sh01 : -8'sh01);
            tx_frame_o <= {1'b1, 1'b0, inv, ictl, scr};
            tx_frame_valid_o <= 1'b1;
            tx_lfsr_r <= step[39:24];
            disparity_r <= disparity_r + delta;
            ctrl_phase_r <= (ctrl_phase_r == 2'h3) ? 2'h0 : ctrl_phase_r + 2'h1;
        end
        else
            tx_frame_valid_o <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            vod_mv_o <= 12'(`VOD_STD_MV);
        else
            vod_mv_o <= cfg_s2_r[0] ? 12'(`VOD_HIGH_MV) : 12'(`VOD_STD_MV);
    end

    // receive decode: lock on clock-bit pattern, any payload
    always_ff @(posedge clk_i)
    begin
        logic [39:0] step;
        logic [23:0] pay;
        logic ierr;
        logic bitv;
        step = lfsr_step(rx_lfsr_r);
        pay = rx_s2_r[23:0];
        ierr = 1'b0;
        bitv = 1'b0;
        if (rst_i)
        begin
            rx_colour_bits_o <= 24'h0;
            rx_frame_sync_o <= 1'b0;
            rx_line_sync_o <= 1'b0;
            rx_pixel_valid_o <= 1'b0;
            rx_gp_bits_o <= 3'h0;
            rx_pixel_strobe_o <= 1'b0;
            rx_lock_o <= 1'b0;
            rx_integrity_err_o <= 1'b0;
            rx_lfsr_r <= `SCRAMBLE_SEED;
            rx_phase_r <= 2'h0;
            idle_cnt_r <= 16'h0;
        end
        else if (rx_s2_r[28] && !rx_prev_valid_r)
        begin
            idle_cnt_r <= 16'h0;
            if (rx_s2_r[27:26] != 2'b10)
            begin
                // framing lost: drop lock and restart the keystream
                rx_lock_o <= 1'b0;
                rx_lfsr_r <= `SCRAMBLE_SEED;
                rx_phase_r <= 2'h0;
                rx_pixel_strobe_o <= 1'b0;
            end
            else
            begin
                bitv = rx_s2_r[24] ^ parity(pay, rx_s2_r[25]);
                if (rx_s2_r[25])
                    pay = ~pay;
                pay = pay ^ step[23:0];
                rx_lfsr_r <= step[39:24];
                rx_lock_o <= 1'b1;
                rx_pixel_strobe_o <= 1'b1;
                rx_phase_r <= (rx_phase_r == 2'h3) ? 2'h0 : rx_phase_r + 2'h1;
                if (cfg_s2_r[3] && cfg_s2_r[2])
                begin
                    ierr = bitv;
                    rx_colour_bits_o <= {pay[23:6], 6'h0};
                    rx_gp_bits_o <= pay[5:3];
                    rx_frame_sync_o <= pay[2];
                    rx_line_sync_o <= pay[1];
                    rx_pixel_valid_o <= pay[0];
                end
                else
                begin
                    rx_colour_bits_o <= pay;
                    case (rx_phase_r)
                        2'h0: rx_frame_sync_o <= bitv;
                        2'h1: rx_line_sync_o <= bitv;
                        2'h2: rx_pixel_valid_o <= bitv;
                        default: ierr = bitv;
                    endcase
                end
                rx_integrity_err_o <= ierr;
            end
        end
        else
        begin
            rx_pixel_strobe_o <= 1'b0;
            // lock falls after a long gap with no frames
            if (idle_cnt_r == `FRAME_TIMEOUT_CYC)
                rx_lock_o <= 1'b0;
            else
                idle_cnt_r <= idle_cnt_r + 16'h1;
        end
    end
endmodule

// ### rtl/pixel_link_params.svh
// constants for the pixel serial link codec: frame layout and timing counts
`ifndef PIXEL_LINK_PARAMS_SVH
`define PIXEL_LINK_PARAMS_SVH
`define FRAME_BITS 28
`define PAYLOAD_BITS 24
`define POS_CLK_HIGH 27
`define POS_CLK_LOW 26
`define POS_BALANCE 25
`define POS_INTEGRITY 24
`define CTRL_SYM_BITS 4
`define SCRAMBLE_SEED 16'hACE1
`define FILTER_MIN_PCLK 3
`define VOD_STD_MV 560
`define VOD_HIGH_MV 840
`define SSC_MAX_KHZ 35
`define SSC_MAX_DEV_PCT 2
`define FRAME_TIMEOUT_CYC 16'h0100
`endif

// ### rtl/pixel_link_pkg.sv
// types shared by the pixel serial link codec
package pixel_link_pkg;
    typedef struct packed {
        logic [23:0] colour_bits;
        logic frame_sync;
        logic line_sync;
        logic pixel_valid;
    } pixel_word_t;
    typedef struct packed {
        logic clock_high_bit;
        logic clock_low_bit;
        logic balance_invert_flag;
        logic integrity_control_bit;
        logic [23:0] payload;
    } link_frame_t;
    typedef enum logic {MODE_24, MODE_18} colour_mode_t;
endpackage

// ### rtl/ctrl_glitch_filter.sv
// control signal glitch filter: a level passes only after being stable
`include "pixel_link_params.svh"
module ctrl_glitch_filter
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic step_i,
    input wire logic enable_i,
    input wire logic raw_i,
    output logic filt_o
);
    // pixel clock steps the raw level has held its current value
    logic [1:0] stable_r;
    logic last_r;

    // track how long the raw level stays put
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stable_r <= 2'h0;
            last_r <= 1'b0;
        end
        else if (step_i)
        begin
            last_r <= raw_i;
            if (raw_i != last_r)
                stable_r <= 2'h0;
            else if (stable_r != 2'h3)
                stable_r <= stable_r + 2'h1;
        end
    end

    // accept a new level after the minimum pulse width; bypass when disabled
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            filt_o <= 1'b0;
        else if (step_i)
        begin
            if (!enable_i)
                filt_o <= raw_i;
            else if (raw_i == last_r && {30'h0, stable_r} >= `FILTER_MIN_PCLK - 2)
                filt_o <= raw_i;
        end
    end
endmodule

// ### verification/pixel_link_sva.sv
// port checker for the pixel link codec
module pixel_link_sva
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pclk_i,
    input wire logic output_level_select_i,
    input wire logic [27:0] rx_frame_i,
    input wire logic rx_frame_valid_i,
    input wire logic [27:0] tx_frame_o,
    input wire logic tx_frame_valid_o,
    input wire logic [11:0] vod_mv_o,
    input wire logic [23:0] rx_colour_bits_o,
    input wire logic rx_pixel_strobe_o,
    input wire logic rx_lock_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // cycles since the far side last held a frame; saturates
    logic [9:0] idle_r;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || rx_frame_valid_i)
            idle_r <= 10'h000;
        else if (idle_r != 10'h3FF)
            idle_r <= idle_r + 10'h001;
    end
    sequence pclk_rise; !pclk_i ##1 pclk_i; endsequence
    sequence rx_rise; !rx_frame_valid_i ##1 rx_frame_valid_i; endsequence
    a_clock_bits_fixed:
    assert property (tx_frame_valid_o |-> tx_frame_o[27:26] == 2'b10)
        else $error("clock bits wrong");
    a_frame_per_pclk:
    assert property (pclk_rise |-> ##[3:5] tx_frame_valid_o)
        else $error("no frame after pixel clock");
    a_frame_pulse_once:
    assert property (tx_frame_valid_o |=> (!tx_frame_valid_o) [*8])
        else $error("frame valid too long");
    a_tx_frame_held:
    assert property ($changed(tx_frame_o) |-> tx_frame_valid_o)
        else $error("frame moved between pixels");
    a_vod_raised:
    assert property (output_level_select_i [*3] |=> vod_mv_o == 12'h348)
        else $error("raised level wrong");
    a_vod_standard:
    assert property ((!output_level_select_i) [*3] |=> vod_mv_o == 12'h230)
        else $error("standard level wrong");
    a_rx_good_strobe:
    assert property (rx_rise ##0 rx_frame_i[27:26] == 2'b10 |-> ##[2:5] rx_pixel_strobe_o)
        else $error("good frame not decoded");
    a_rx_bad_refused:
    assert property (rx_rise ##0 rx_frame_i[27:26] != 2'b10
        |-> (!rx_pixel_strobe_o) [*6] ##1 !rx_lock_o)
        else $error("bad frame accepted");
    a_lock_lapses:
    assert property (idle_r >= 10'h10E |-> !rx_lock_o)
        else $error("lock held on idle line");
    a_rx_out_held:
    assert property ($changed(rx_colour_bits_o) |-> rx_pixel_strobe_o)
        else $error("colour moved without strobe");
endmodule
bind pixel_serial_link_codec pixel_link_sva i_sva
(
    .clk_i, .rst_i, .pclk_i, .output_level_select_i, .rx_frame_i, .rx_frame_valid_i,
    .tx_frame_o, .tx_frame_valid_o, .vod_mv_o, .rx_colour_bits_o, .rx_pixel_strobe_o,
    .rx_lock_o
);

// ### verification/link_loopback_model.sv
// far receiver model: echoes each sent frame back, optionally damaged
module link_loopback_model
(
    input wire logic clk_i,
    input wire logic [27:0] tx_frame_i,
    input wire logic tx_valid_i,
    input wire logic [1:0] corrupt_i,
    output logic [27:0] frame_o,
    output logic valid_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] hold_r = 4'h0;
    initial frame_o = 28'h0;
    assign valid_o = hold_r != 4'h0;
    always @(posedge clk_i)
    begin
        if (tx_valid_i)
        begin
            hold_r <= 4'h8;
            frame_o <= tx_frame_i ^ {corrupt_i[1], 26'h0, corrupt_i[0]};
        end
        else if (hold_r != 4'h0)
        begin
            hold_r <= hold_r - 4'h1;
            // released lines must not keep the old frame
            if (hold_r == 4'h1)
                frame_o <= ~frame_o;
        end
    end
endmodule

// ### verification/pixel_serial_link_codec_tb.sv
// loopback bench for the pixel link codec
module pixel_serial_link_codec_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pclk = 1'b0;
    logic run = 1'b0;
    logic mode18 = 1'b0;
    logic in_pay = 1'b0;
    logic filt = 1'b0;
    logic lvl = 1'b0;
    logic [1:0] corrupt = 2'h0;
    logic [2:0] gp = 3'h0;
    logic [2:0] ctl = 3'h0;
    logic [23:0] col = 24'h000000;
    logic [31:0] seed = 32'h00015F5F;
    wire pixel_link_pkg::pixel_word_t rxp;
    pixel_link_pkg::link_frame_t txf;
    logic [27:0] rxf;
    logic [11:0] vod;
    logic [2:0] rx_gp;
    logic txv, rxv, strobe, lock, ierr;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    int disp = 0;
    int fcount = 0; // frames sent since reset
    pixel_serial_link_codec i_dut
    (
        .clk_i(clk), .rst_i(rst), .pclk_i(pclk), .colour_bits_i(col),
        .frame_sync_i(ctl[2]), .line_sync_i(ctl[1]), .pixel_valid_i(ctl[0]),
        .gp_bits_i(gp), .mode_18_i(mode18), .ctrl_in_payload_i(in_pay),
        .filter_en_i(filt), .output_level_select_i(lvl), .rx_frame_i(rxf),
        .rx_frame_valid_i(rxv), .tx_frame_o(txf), .tx_frame_valid_o(txv), .vod_mv_o(vod),
        .rx_colour_bits_o(rxp.colour_bits), .rx_frame_sync_o(rxp.frame_sync),
        .rx_line_sync_o(rxp.line_sync), .rx_pixel_valid_o(rxp.pixel_valid),
        .rx_gp_bits_o(rx_gp), .rx_pixel_strobe_o(strobe), .rx_lock_o(lock),
        .rx_integrity_err_o(ierr)
    );
    link_loopback_model i_far
    (
        .clk_i(clk), .tx_frame_i(txf), .tx_valid_i(txv), .corrupt_i(corrupt),
        .frame_o(rxf), .valid_o(rxv)
    );
    always #2.5 clk = ~clk;
    // pixel clock offset from clk, frozen low while stopped
    initial
    begin
        #1.3;
        forever #62.5 pclk = run ? ~pclk : 1'b0;
    end
    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_count++;
            tally_and_finish();
        end
    end
    // every frame sent counts toward line disparity and control rotation
    always @(posedge clk)
    begin
        if (rst)
        begin
            fcount <= 0;
            disp <= 0;
        end
        else if (txv === 1'b1)
        begin
            fcount <= fcount + 1;
            disp <= disp + 2 * $countones(txf) - 28;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // 18-bit payload option keeps only the top colour bits
    function automatic logic [23:0] exp_col(input logic m, input logic [23:0] c);
        return m ? {c[23:6], 6'h00} : c;
    endfunction
    task automatic chk(input string what, input logic [27:0] seen, input logic [27:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one pixel: 0 random, 1 all zeros, 2 all ones
    task automatic pixel(input logic [1:0] kind);
        @(negedge pclk);
        tick(1);
        seed = xs(seed);
        col = kind == 2'h0 ? seed[23:0] : {24{kind[1]}};
        gp = seed[26:24];
        repeat (60) if (txv !== 1'b1) @(negedge clk);
        chk("clock bits", {txf.clock_high_bit, txf.clock_low_bit}, 2'h2);
        chk("raw payload", txf.payload == col || txf.payload == ~col, 1'b0);
        chk("disparity", disp > 64 || disp < -64, 1'b0);
        repeat (20) if (strobe !== 1'b1) @(negedge clk);
        chk("lock", lock, !corrupt[1]);
        if (!corrupt[1])
            chk("integrity", ierr, corrupt[0]);
        if (corrupt == 2'h0)
            chk("colour", rxp.colour_bits, exp_col(mode18 & in_pay, col));
        if (in_pay)
            chk("payload ctl", {rx_gp, rxp[2:0]}, {gp, ctl});
        // realign so later stimulus changes just after a rising edge
        tick(1);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        tick(10);
        rst = 1'b0;
        run = 1'b1;
        // one control change per 130 pixels
        for (int b = 0; b < 3; b++)
        begin
            filt = b[0];
            ctl = seed[2:0];
            for (int p = 0; p < 130; p++)
                pixel(p < 8 ? 2'h1 : (p < 16 ? 2'h2 : 2'h0));
            chk("controls", rxp[2:0], ctl);
            $display("test control block %0d done", b);
        end
        // a one-pixel line sync spike must be filtered out
        filt = 1'b1;
        ctl[1] = ~ctl[1];
        pixel(2'h0);
        ctl[1] = ~ctl[1];
        repeat (12) pixel(2'h0);
        chk("glitch", rxp.line_sync, ctl[1]);
        $display("test glitch done");
        // 18-bit mode: controls in payload, then encoded
        filt = 1'b0;
        mode18 = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            in_pay = k == 0;
            repeat (10) pixel(2'h0);
            $display("test 18-bit option %0d done", k);
        end
        mode18 = 1'b0;
        in_pay = 1'b0;
        // damage a payload bit only on the pure-parity frame of the rotation
        repeat (4)
        begin
            corrupt = {1'b0, fcount[1:0] == 2'h3};
            pixel(2'h0);
        end
        corrupt = 2'h0;
        // silent line: lock must lapse
        run = 1'b0;
        tick(400);
        chk("idle lock", lock, 1'b0);
        run = 1'b1;
        corrupt = 2'h2;
        pixel(2'h0);
        corrupt = 2'h0;
        $display("test faults done");
        // second reset in mid-run, then clean traffic and output level
        run = 1'b0;
        rst = 1'b1;
        tick(10);
        chk("vod reset", vod, 12'h230);
        rst = 1'b0;
        run = 1'b1;
        repeat (5) pixel(2'h0);
        lvl = 1'b1;
        tick(4);
        chk("vod", vod, 12'h348);
        lvl = 1'b0;
        tick(4);
        chk("vod", vod, 12'h230);
        $display("test reset and level done");
        tally_and_finish();
    end
endmodule
